// file: src/edmon_top.v
// External device monitor: one monitor channel per generate slice
`timescale 1ns/10ps
`default_nettype none
`include "edmon_defines.vh"
module edmon_top #(
    parameter NCH = 2,
    parameter NOUT = 4,
    parameter [`EDMON_CNT_W-1:0] LIMIT_CYC = `EDMON_LIMIT_CYC
) (
    input wire ref_clk_in,
    input wire resetn_in,
    input wire [NCH-1:0] mode_two_in,
    input wire [NCH*NOUT-1:0] assign_map_in,
    input wire [NOUT-1:0] monitor_enable_in,
    input wire [NCH-1:0] ext_device_monitor_input_a_in,
    input wire [NCH-1:0] ext_device_monitor_input_b_in,
    input wire [NOUT-1:0] out_request_in,
    input wire [NOUT-1:0] reset_request_in,
    input wire [NCH-1:0] fault_clear_in,
    output reg [NOUT-1:0] safety_switching_output_out,
    output wire [NOUT-1:0] out_permit_out,
    output reg [NCH-1:0] lockout_out,
    output reg [NCH-1:0] stuck_on_out
);
    wire [NOUT-1:0] any_on;
    wire [NCH-1:0] ch_ok;
    wire [NCH-1:0] ch_lock;
    wire [NCH-1:0] ch_stuck;
    genvar c, o;
    // ==========================================
    // Monitor channels
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_ch
            wire [NOUT-1:0] mine = assign_map_in[c*NOUT +: NOUT] & monitor_enable_in;
            wire outs_on = |(mine & safety_switching_output_out);
            wire a_closed = (ext_device_monitor_input_a_in[c] == `EDMON_CLOSED);
            wire b_closed = (ext_device_monitor_input_b_in[c] == `EDMON_CLOSED);
            wire two = (mode_two_in[c] == `EDMON_MODE_TWO);
            wire both_closed = two ? (a_closed & b_closed) : a_closed;
            wire disagree = two & (a_closed ^ b_closed);
            reg [1:0] st_reg;
            reg [1:0] st_next;
            wire dis_exp;
            wire close_exp;
            // Mismatch timer runs in any state; matched transitions restart it
            edmon_timer #(.LIMIT(LIMIT_CYC)) u_dis (
                .ref_clk_in(ref_clk_in),
                .resetn_in(resetn_in),
                .run_in(disagree),
                .expired_out(dis_exp)
            );
            edmon_timer #(.LIMIT(LIMIT_CYC)) u_close (
                .ref_clk_in(ref_clk_in),
                .resetn_in(resetn_in),
                .run_in(st_reg == `EDMON_ST_WAIT && !both_closed),
                .expired_out(close_exp)
            );
            always @* begin
                st_next = st_reg;
                case (st_reg)
                    `EDMON_ST_OFF: begin
                        if (outs_on) begin
                            st_next = `EDMON_ST_ON;
                        end
                    end
                    `EDMON_ST_ON: begin
                        // Contact ignored while on in one-channel mode
                        if (!outs_on) begin
                            st_next = `EDMON_ST_WAIT;
                        end
                    end
                    `EDMON_ST_WAIT: begin
                        if (close_exp) begin
                            st_next = `EDMON_ST_LOCK;
                        end else if (both_closed) begin
                            st_next = `EDMON_ST_OFF;
                        end
                    end
                    `EDMON_ST_LOCK: begin
                        if (fault_clear_in[c] && both_closed && !disagree) begin
                            st_next = `EDMON_ST_OFF;
                        end
                    end
                    default: begin
                        st_next = `EDMON_ST_LOCK;
                    end
                endcase
                if (dis_exp) begin
                    st_next = `EDMON_ST_LOCK;
                end
            end
            always @(posedge ref_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    st_reg <= `EDMON_ST_OFF;
                end else begin
                    st_reg <= st_next;
                end
            end
            // Turn-on needs closed contacts and no pending deadline
            assign ch_ok[c] = both_closed && (st_reg == `EDMON_ST_OFF);
            assign ch_lock[c] = (st_reg == `EDMON_ST_LOCK);
            // Open contact while a close deadline runs is not yet a stuck device
            assign ch_stuck[c] = ((st_reg == `EDMON_ST_OFF) || (st_reg == `EDMON_ST_LOCK)) && !both_closed;
        end
    endgenerate
    // ==========================================
    // Output gating
    generate
        for (o = 0; o < NOUT; o = o + 1) begin : g_out
            wire [NCH-1:0] users;
            for (c = 0; c < NCH; c = c + 1) begin : g_u
                assign users[c] = assign_map_in[c*NOUT + o] & monitor_enable_in[o];
            end
            // Locked channels force their outputs off; unmonitored outputs pass freely
            assign out_permit_out[o] = ((users & ch_ok) == users) && ((users & ch_lock) == {NCH{1'b0}});
            wire blocked = |(users & ch_lock);
            always @(posedge ref_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    safety_switching_output_out[o] <= 1'b0;
                end else if (!out_request_in[o] || blocked) begin
                    safety_switching_output_out[o] <= 1'b0;
                end else if (reset_request_in[o] && out_permit_out[o]) begin
                    safety_switching_output_out[o] <= 1'b1;
                end
            end
        end
    endgenerate
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lockout_out <= {NCH{1'b0}};
            stuck_on_out <= {NCH{1'b0}};
        end else begin
            lockout_out <= ch_lock;
            stuck_on_out <= ch_stuck;
        end
    end
endmodule // edmon_top
`default_nettype wire

// file: src/edmon_defines.vh
// Constants for the external device monitor block
// Functional notes
// - Each monitor channel is set to one-channel or two-channel operation.
// - One monitor channel may supervise one or several safety outputs at once.
// - No monitoring applies unless an output's monitor node is enabled.
// - In one-channel mode a reset of the assigned outputs is refused unless the contact reads closed.
// - In one-channel mode the contact is ignored while the assigned outputs are on.
// - In one-channel mode the contact must read closed within 250 ms after the outputs turn off.
// - In two-channel mode reset and turn-on need both contacts closed.
// - In two-channel mode both contacts changing together while on is no fault.
// - In two-channel mode contacts held in opposite states over 250 ms cause lockout.
// - A contact open while outputs are off is a stuck device and blocks turn-on; the code does not flag it stuck while the close deadline runs.
`ifndef EDMON_DEFINES_VH
`define EDMON_DEFINES_VH
// ==========================================
// Timing
`define EDMON_CLK_HZ 200000000
`define EDMON_LIMIT_MS 250
// 250 ms of the 200 MHz clock, sized to the counter so no bits are dropped
`define EDMON_LIMIT_CYC 26'h2FAF080
`define EDMON_CNT_W 26
// ==========================================
// Contact levels and modes
`define EDMON_CLOSED 1'h1
`define EDMON_MODE_ONE 1'h0
`define EDMON_MODE_TWO 1'h1
// ==========================================
// Channel states
`define EDMON_ST_OFF 2'h0
`define EDMON_ST_ON 2'h1
`define EDMON_ST_WAIT 2'h2
`define EDMON_ST_LOCK 2'h3
`endif

// file: src/edmon_timer.v
// Limit timer: counts while run is high, flags expiry
`timescale 1ns/10ps
`default_nettype none
`include "edmon_defines.vh"
module edmon_timer #(
    parameter [`EDMON_CNT_W-1:0] LIMIT = `EDMON_LIMIT_CYC
) (
    input wire ref_clk_in,
    input wire resetn_in,
    input wire run_in,
    output wire expired_out
);
    reg [`EDMON_CNT_W-1:0] count_reg;
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_reg <= {`EDMON_CNT_W{1'b0}};
        end else if (!run_in) begin
            count_reg <= {`EDMON_CNT_W{1'b0}};
        end else if (count_reg != LIMIT) begin
            count_reg <= count_reg + {{(`EDMON_CNT_W-1){1'b0}}, 1'b1};
        end
    end
    assign expired_out = (count_reg == LIMIT);
endmodule // edmon_timer
`default_nettype wire

// file: verification/edmon_chk.sv
// Port checker for the external device monitor, channel 0 and its outputs
`timescale 1ns/10ps
`default_nettype none
`include "edmon_defines.vh"
module edmon_chk #(parameter NCH = 1, parameter NOUT = 2, parameter [`EDMON_CNT_W-1:0] LIMIT_CYC = 20) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [NCH-1:0] mode_two_in,
    input wire logic [NCH*NOUT-1:0] assign_map_in,
    input wire logic [NOUT-1:0] monitor_enable_in,
    input wire logic [NCH-1:0] ext_device_monitor_input_a_in,
    input wire logic [NCH-1:0] ext_device_monitor_input_b_in,
    input wire logic [NOUT-1:0] out_request_in,
    input wire logic [NOUT-1:0] reset_request_in,
    input wire logic [NCH-1:0] fault_clear_in,
    input wire logic [NOUT-1:0] safety_switching_output_out,
    input wire logic [NOUT-1:0] out_permit_out,
    input wire logic [NCH-1:0] lockout_out,
    input wire logic [NCH-1:0] stuck_on_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!resetn_in);
wire logic [NOUT-1:0] so = safety_switching_output_out;
wire logic a0 = ext_device_monitor_input_a_in[0];
wire logic b0 = ext_device_monitor_input_b_in[0];
wire logic two0 = mode_two_in[0];
wire logic mon0 = assign_map_in[0] && monitor_enable_in[0];
wire logic take0 = out_permit_out[0] && out_request_in[0] && reset_request_in[0];
logic [31:0] wait_cnt;
logic [31:0] skew_cnt;
// ==========================================
// Run lengths of open or disagreeing contacts; a counter keeps long waits out of repetitions
always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        wait_cnt <= 0;
        skew_cnt <= 0;
    end else begin
        wait_cnt <= (($fell(so[0]) || wait_cnt != 0) && !a0) ? wait_cnt + 1 : 0;
        skew_cnt <= (two0 && a0 != b0) ? skew_cnt + 1 : 0;
    end
end
// ==========================================
// Assertions
AST_PERMIT_TURNON: assert property ($rose(so[0]) |-> $past(take0)) else $error("output rose without accepted reset");
AST_DROP: assert property (!out_request_in[0] |=> !so[0]) else $error("output stayed on without request");
AST_LOCK_OFF: assert property (lockout_out[0] && mon0 && !fault_clear_in[0] && !$past(fault_clear_in[0]) |=> !so[0])
    else $error("locked output is on");
AST_PERMIT_CLOSED: assert property (out_permit_out[0] && mon0 |-> a0 && (!two0 || b0)) else $error("permit with open contact");
AST_DISAGREE: assert property (skew_cnt == LIMIT_CYC + 4 |-> lockout_out[0]) else $error("no lockout on disagreement");
AST_DEADLINE: assert property (wait_cnt == LIMIT_CYC + 4 && mon0 && !two0 |-> lockout_out[0]) else $error("missed deadline not locked");
AST_UNMON: assert property (!monitor_enable_in[1] && out_request_in[1] && reset_request_in[1] |=> so[1])
    else $error("unmonitored output refused");
AST_ON_IGNORE: assert property (so[0] && out_request_in[0] && mon0 && !two0 |=> so[0]) else $error("contact change dropped output");
endmodule // edmon_chk
bind edmon_top edmon_chk #(.NCH(NCH), .NOUT(NOUT), .LIMIT_CYC(LIMIT_CYC)) edmon_chk_inst (.ref_clk_in, .resetn_in,
    .mode_two_in, .assign_map_in, .monitor_enable_in, .ext_device_monitor_input_a_in, .ext_device_monitor_input_b_in,
    .out_request_in, .reset_request_in, .fault_clear_in, .safety_switching_output_out, .out_permit_out, .lockout_out,
    .stuck_on_out);
`default_nettype wire

// file: verification/edmon_contact.sv
// Force-guided monitor contact of one external switching device
`timescale 1ns/10ps
`default_nettype none
module edmon_contact (
    input wire logic ref_clk_in,
    input wire logic energize_in,
    input wire logic weld_in,
    input wire logic [7:0] lag_in,
    output logic closed_out
);
logic [7:0] cnt_reg = 8'h00;
initial closed_out = 1'h1;
// ==========================================
// Opens at once when energized, closes lag_in cycles after release; a weld keeps it open
always @(posedge ref_clk_in) begin
    if (energize_in || weld_in) begin
        cnt_reg <= 8'h00;
        closed_out <= 1'h0;
    end else if (cnt_reg >= lag_in) begin
        closed_out <= 1'h1;
    end else begin
        cnt_reg <= cnt_reg + 8'h01;
    end
end
endmodule // edmon_contact
`default_nettype wire

// file: verification/external_device_monitor_test.sv
// Self-checking bench for the external device monitor
`timescale 1ns/10ps
`default_nettype none
module external_device_monitor_test;
logic ref_clk_in = 1'h0;
logic resetn_in = 1'h0;
logic two = 1'h0, wa = 1'h0, wb = 1'h0, clr = 1'h0, lock, stuck, ca, cb;
logic [1:0] en = 2'h3, req = 2'h0, rr = 2'h0, so, pm;
logic [7:0] lag = 8'h05;
int num_errors = 0;
int num_checks = 0;
always #2.5 ref_clk_in = !ref_clk_in;
edmon_top #(.NCH(1), .NOUT(2), .LIMIT_CYC(20)) edmon_top_inst (.ref_clk_in, .resetn_in, .mode_two_in(two),
    .assign_map_in(2'h3), .monitor_enable_in(en), .ext_device_monitor_input_a_in(ca),
    .ext_device_monitor_input_b_in(cb), .out_request_in(req), .reset_request_in(rr), .fault_clear_in(clr),
    .safety_switching_output_out(so), .out_permit_out(pm), .lockout_out(lock), .stuck_on_out(stuck));
edmon_contact contact_a_inst (.ref_clk_in, .energize_in(so[0]), .weld_in(wa), .lag_in(lag), .closed_out(ca));
edmon_contact contact_b_inst (.ref_clk_in, .energize_in(so[0]), .weld_in(wb), .lag_in(lag), .closed_out(cb));
task cyc(input int n); repeat (n) @(posedge ref_clk_in); #1; endtask
task chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
        num_errors++;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
endtask
task end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask
task go_on; req = 2'h3; rr = 2'h3; cyc(1); rr = 2'h0; cyc(2); endtask
task go_off; req = 2'h0; cyc(2); endtask
task clear; clr = 1'h1; cyc(1); clr = 1'h0; cyc(2); endtask
task t_prompt;
    go_on();
    cyc(3);
    chk("outputs on, contacts open", so, 2'h3);
    go_off();
    cyc(30);
    chk("lockout", lock, 2'h0);
    chk("permit", pm, 2'h3);
endtask
task t_slow;
    lag = 8'h28;
    go_on();
    go_off();
    cyc(3);
    chk("permit", pm, 2'h0);
    cyc(22);
    chk("lockout", lock, 2'h1);
    chk("stuck", stuck, 2'h1);
    go_on();
    chk("outputs", so, 2'h0);
    go_off();
    cyc(20);
    clear();
    chk("lockout cleared", lock, 2'h0);
    lag = 8'h05;
endtask
task t_two;
    two = 1'h1;
    go_on();
    cyc(5);
    chk("both open while on", {lock, so[0]}, 2'h1);
    wb = 1'h1;
    go_off();
    cyc(10);
    chk("permit", pm, 2'h0);
    cyc(25);
    chk("lockout", lock, 2'h1);
    wb = 1'h0;
    cyc(10);
    clear();
    chk("lockout cleared", lock, 2'h0);
    // One contact opens while off: no turn-on, then lockout once the mismatch outlasts the limit
    wb = 1'h1;
    cyc(2);
    go_on();
    chk("outputs, one contact open", so, 2'h0);
    chk("permit, one contact open", pm, 2'h0);
    go_off();
    cyc(9);
    chk("no early lockout", lock, 2'h0);
    cyc(10);
    chk("lockout on mismatch", lock, 2'h1);
    wb = 1'h0;
    cyc(10);
    clear();
    two = 1'h0;
endtask
task t_unmon;
    en = 2'h1;
    wa = 1'h1;
    // The weld shows one edge later; the request must not race it
    cyc(2);
    go_on();
    chk("outputs", so, 2'h2);
    chk("permit", pm, 2'h2);
    chk("stuck while off", stuck, 2'h1);
    go_off();
    wa = 1'h0;
    en = 2'h3;
    cyc(10);
endtask
initial begin #5000; num_errors++; end_of_test(); end
initial begin
    cyc(4);
    chk("outputs in reset", so, 2'h0);
    chk("flags in reset", {lock, stuck}, 2'h0);
    resetn_in = 1'h1;
    cyc(1);
    t_prompt();
    t_slow();
    t_two();
    t_unmon();
    end_of_test();
end
endmodule // external_device_monitor_test
`default_nettype wire
